// ===== inc/card_pkg.sv
// shared constants and types for the card host port, both ends
// assumes both ends compile against this one package
package card_pkg;

    localparam int DATA_W = 16;

    // clk cycles per link half period, less one
    localparam logic [3:0] LINK_HALF_M1 = 4'h7;
    // clk cycles per strobe phase
    localparam logic [7:0] STEP_CYCLES = 8'h40;
    // link cycles busy after any reset
    localparam logic [7:0] BUSY_CYCLES = 8'h40;
    // link cycles of a pulse interrupt
    localparam logic [7:0] PULSE_CYCLES = 8'h04;
    // pace count at which the card strobe toggles
    localparam logic [1:0] PACE_STROBE = 2'h2;

    typedef enum logic [2:0] {
        OP_MEM_READ  = 3'h0,
        OP_IO_READ   = 3'h1,
        OP_IO_WRITE  = 3'h2,
        OP_DMA_WRITE = 3'h3,
        OP_DMA_STOP  = 3'h4
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_SETUP  = 2'h1,
        ST_STROBE = 2'h2,
        ST_HOLD   = 2'h3
    } host_state_t;

endpackage

// ===== inc/card_link_if.sv
// socket pins between the host controller and the card
// assumes the host end makes link_clk; the bench joins the ends
interface card_link_if;
    logic                        link_clk;          // host-made clock
    logic                        reset_pin;         // card reset pin
    logic                        output_enable_n;   // also disk_mode_select_n
    logic                        io_read_strobe_n;  // also dma ready / data strobe
    logic                        io_write_strobe_n; // also dma stop
    logic                        ready_irq;         // ready or interrupt request
    logic                        dev_strobe;        // card dma-in word strobe
    logic [card_pkg::DATA_W-1:0] host_data;         // host data out
    logic                        host_data_oe;      // host drives bus
    logic [card_pkg::DATA_W-1:0] dev_data;          // card data out
    logic                        dev_data_oe;       // card drives bus
    logic [card_pkg::DATA_W-1:0] data_bus;          // resolved bus level

    // pull-ups hold the bus high when nobody drives
    assign data_bus = dev_data_oe ? dev_data
                    : host_data_oe ? host_data : 16'hFFFF;

    modport card (
        input  link_clk, reset_pin, output_enable_n, io_read_strobe_n,
        input  io_write_strobe_n, data_bus,
        output ready_irq, dev_strobe, dev_data, dev_data_oe
    );

    modport host (
        input  ready_irq, dev_strobe, data_bus,
        output link_clk, reset_pin, output_enable_n, io_read_strobe_n,
        output io_write_strobe_n, host_data, host_data_oe
    );
endinterface

// ===== hw/pin_sync.sv
// two flop synchroniser for a group of pins
// assumes slow levels; no reset
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,  // destination clock
    input  wire logic [W-1:0] d,    // asynchronous levels
    output logic      [W-1:0] q     // synchronised levels
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk)
    begin
        meta_reg <= d;
        q        <= meta_reg;
    end
endmodule

// ===== hw/card_device.sv
// card end of the host port: strobes, output enable, ready and irq
// assumes link_clk from the host; srst in its domain
//
// Operation
// RULE1: io read data only while read strobe low
// RULE2: disk mode non-dma read strobe as io
// RULE3: dma-in pauses while host ready negated
// RULE4: dma-out latches on both strobe edges
// RULE5: strobe gaps lose or repeat no words
// RULE6: io write captured on strobe rising edge
// RULE7: host keeps write strobe negated before dma
// RULE8: stop assertion ends the dma burst
// RULE9: memory mode output enable returns data
// RULE10: io mode output enable reads attribute data
// RULE11: host grounds mode select for disk mode
// RULE12: memory mode ready high, low while busy
// RULE13: ready low until reset processing done
// RULE14: host waits while ready shows busy
// RULE15: reset held from power-up is ignored
// RULE16: ready pin becomes irq once io configured
// RULE17: pulse irq strobes low, level holds low
// RULE18: disk mode irq is active high
// RULE19: reset pin high or soft reset resets
// RULE20: disk mode reset pin is active low
module card_device (
    card_link_if.card                    link,           // socket pins
    input  wire logic                    srst,           // power-on reset
    input  wire logic                    io_configured,  // io interface set up
    input  wire logic                    soft_reset,     // config soft reset bit
    input  wire logic                    irq_pulse_mode, // pulse rather than level
    input  wire logic                    irq_request,    // interrupt wanted
    input  wire logic                    user_busy,      // cannot take transfers
    input  wire logic                    udma_write_en,  // dma-out active
    input  wire logic                    udma_read_en,   // dma-in active
    input  wire logic [card_pkg::DATA_W-1:0] rd_data,    // data or dma word
    input  wire logic [card_pkg::DATA_W-1:0] attr_data,  // attribute space word
    output logic                         disk_interface_mode, // strap seen
    output logic                         reset_active,   // reset or busy
    output logic                         wr_valid,       // word written
    output logic [card_pkg::DATA_W-1:0]  wr_data,        // written word
    output logic                         burst_stop,     // burst ended
    output logic                         rd_take         // rd_data consumed
);
    logic [19:0] pins_s;
    logic        rst_s;
    logic        oe_n_s;
    logic        rd_n_s;
    logic        wr_n_s;
    logic [card_pkg::DATA_W-1:0] bus_s;
    logic        rd_n_d_reg;
    logic        wr_n_d_reg;
    logic        start_reg;
    logic        armed_reg;
    logic [7:0]  busy_cnt_reg;
    logic        stopped_reg;
    logic [1:0]  pace_reg;
    logic        irq_d_reg;
    logic [7:0]  pulse_cnt_reg;
    logic        pin_rst;
    logic        any_rst;
    logic        busy;
    logic        io_mode;
    logic        dma_rd;
    logic        dma_wr;
    logic        strobe_mode;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and decode

    pin_sync #(.W (20)) u_sync (
        .clk (link.link_clk),
        .d   ({link.reset_pin, link.output_enable_n, link.io_read_strobe_n,
               link.io_write_strobe_n, link.data_bus}),
        .q   (pins_s)
    );

    assign rst_s  = pins_s[19];
    assign oe_n_s = pins_s[18];
    assign rd_n_s = pins_s[17];
    assign wr_n_s = pins_s[16];
    assign bus_s  = pins_s[15:0];

    // RULE20: active low
    // RULE19: active high
    assign pin_rst = disk_interface_mode ? ~rst_s : rst_s;
    // RULE19: soft reset
    assign any_rst = (armed_reg & pin_rst) | (soft_reset & ~disk_interface_mode);
    assign busy    = busy_cnt_reg != 8'h00;
    assign io_mode = io_configured & ~disk_interface_mode;
    assign dma_rd  = disk_interface_mode & udma_read_en;
    assign dma_wr  = disk_interface_mode & udma_write_en;
    // RULE2: disk mode as io
    assign strobe_mode = (io_mode | (disk_interface_mode & ~dma_rd & ~dma_wr)) & ~busy;

    ////////////////////////////////////////////////////////////////////////
    // strap capture and reset handling

    always_ff @(posedge link.link_clk)
    begin
        if (srst)
        begin
            start_reg           <= 1'b1;
            disk_interface_mode <= 1'b0;
            armed_reg           <= 1'b0;
        end
        else
        begin
            start_reg <= 1'b0;
            // strap: only the level at reset release counts
            if (start_reg)
                disk_interface_mode <= ~oe_n_s;
            // RULE15: pin ignored until seen released
            if (!start_reg && !pin_rst)
                armed_reg <= 1'b1;
        end
    end

    // RULE13: busy after reset
    always_ff @(posedge link.link_clk)
    begin
        if (srst || any_rst)
            busy_cnt_reg <= card_pkg::BUSY_CYCLES;
        else if (busy)
            busy_cnt_reg <= busy_cnt_reg - 8'h01;
        reset_active <= srst | any_rst | busy;
    end

    ////////////////////////////////////////////////////////////////////////
    // strobe edges, writes and dma-out

    always_ff @(posedge link.link_clk)
    begin
        if (srst)
        begin
            rd_n_d_reg  <= 1'b1;
            wr_n_d_reg  <= 1'b1;
            stopped_reg <= 1'b0;
            wr_valid    <= 1'b0;
            wr_data     <= 16'h0000;
            burst_stop  <= 1'b0;
        end
        else
        begin
            rd_n_d_reg <= rd_n_s;
            wr_n_d_reg <= wr_n_s;
            wr_valid   <= 1'b0;
            burst_stop <= 1'b0;
            // RULE8: stop ends burst
            if ((dma_rd || dma_wr) && !wr_n_s)
            begin
                stopped_reg <= 1'b1;
                burst_stop  <= ~stopped_reg;
            end
            else if (!dma_rd && !dma_wr)
                stopped_reg <= 1'b0;
            // RULE4: both strobe edges
            // RULE5: no edge, no word
            // RULE6: trailing edge capture
            if ((dma_wr && !stopped_reg && wr_n_s && (rd_n_s != rd_n_d_reg))
                || (strobe_mode && wr_n_s && !wr_n_d_reg))
            begin
                wr_valid <= 1'b1;
                wr_data  <= bus_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data drive and dma-in pacing

    always_ff @(posedge link.link_clk)
    begin
        if (srst)
        begin
            link.dev_data_oe <= 1'b0;
            link.dev_data    <= 16'h0000;
            link.dev_strobe  <= 1'b0;
            pace_reg         <= 2'h0;
            rd_take          <= 1'b0;
        end
        else
        begin
            rd_take          <= 1'b0;
            pace_reg         <= 2'h0;
            link.dev_data_oe <= 1'b0;
            if (dma_rd && !stopped_reg)
            begin
                link.dev_data_oe <= 1'b1;
                // RULE3: word starts only when host ready
                if (pace_reg != 2'h0 || !rd_n_s)
                    pace_reg <= pace_reg + 2'h1;
                if (pace_reg == 2'h0 && !rd_n_s)
                begin
                    link.dev_data <= rd_data;
                    rd_take       <= 1'b1;
                end
                // strobe trails data: host never sees a stale word
                if (pace_reg == card_pkg::PACE_STROBE)
                    link.dev_strobe <= ~link.dev_strobe;
            end
            // RULE1: drive only while strobe low
            else if (strobe_mode && !rd_n_s)
            begin
                link.dev_data_oe <= 1'b1;
                link.dev_data    <= rd_data;
            end
            // RULE9: memory read
            // RULE10: io mode attribute only
            else if (!disk_interface_mode && !busy && !oe_n_s)
            begin
                link.dev_data_oe <= 1'b1;
                link.dev_data    <= io_mode ? attr_data : rd_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ready / interrupt pin

    always_ff @(posedge link.link_clk)
    begin
        if (srst)
        begin
            irq_d_reg     <= 1'b0;
            pulse_cnt_reg <= 8'h00;
            link.ready_irq <= 1'b0;
        end
        else
        begin
            irq_d_reg <= irq_request;
            // RULE17: pulse width
            if (irq_request && !irq_d_reg)
                pulse_cnt_reg <= card_pkg::PULSE_CYCLES;
            else if (pulse_cnt_reg != 8'h00)
                pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
            // RULE18: active high irq
            if (disk_interface_mode)
                link.ready_irq <= irq_request;
            // RULE16: irq once configured
            // RULE17: pulse or level
            else if (io_mode)
                link.ready_irq <= irq_pulse_mode ? (pulse_cnt_reg == 8'h00)
                                                 : ~irq_request;
            // RULE12: ready level
            // RULE13: low while busy
            else
                link.ready_irq <= ~busy & ~user_busy & ~any_rst;
        end
    end
endmodule

// ===== hw/card_host.sv
// host controller end: makes the link clock and runs strobe cycles
// assumes clk is free running; commands come one at a time
module card_host (
    input  wire logic                        clk,            // host clock
    input  wire logic                        srst,           // sync reset
    card_link_if.host                        link,           // socket pins
    input  wire logic                        card_reset_req, // reset the card
    input  wire logic                        ata_select,     // disk mode wanted
    input  wire logic                        io_configured,  // card set for io
    input  wire logic                        dma_read_en,    // dma-in, host ready
    input  wire logic                        dma_write_en,   // dma-out active
    input  wire logic                        cmd_valid,      // command offered
    input  wire card_pkg::op_t               cmd_op,         // command kind
    input  wire logic [card_pkg::DATA_W-1:0] cmd_data,       // write word
    output logic                             cmd_ready,      // command taken
    output logic                             rsp_valid,      // read word
    output logic [card_pkg::DATA_W-1:0]      rsp_data,       // read data
    output logic                             card_ready,     // ready pin level
    output logic                             irq             // interrupt seen
);
    logic [17:0]                 pins_s;
    logic                        ready_s;
    logic                        dstr_s;
    logic [card_pkg::DATA_W-1:0] bus_s;
    logic                        dstr_d_reg;
    logic [3:0]                  div_reg;
    card_pkg::host_state_t       state_reg;
    card_pkg::op_t               op_reg;
    logic [7:0]                  step_reg;
    logic [7:0]                  settle_reg;
    logic                        ready_ok;
    logic                        step_done;

    ////////////////////////////////////////////////////////////////////////
    // link clock divider

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            div_reg       <= 4'h0;
            link.link_clk <= 1'b0;
        end
        else if (div_reg == card_pkg::LINK_HALF_M1)
        begin
            div_reg       <= 4'h0;
            link.link_clk <= ~link.link_clk;
        end
        else
            div_reg <= div_reg + 4'h1;
    end

    pin_sync #(.W (18)) u_sync (
        .clk (clk),
        .d   ({link.ready_irq, link.dev_strobe, link.data_bus}),
        .q   (pins_s)
    );

    assign ready_s = pins_s[17];
    assign dstr_s  = pins_s[16];
    assign bus_s   = pins_s[15:0];

    // RULE14: no access while busy
    assign ready_ok  = settle_reg == 8'h00 && !card_reset_req
                       && (ata_select || io_configured || ready_s);
    assign step_done = step_reg == 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // reset pin, settle timer and status

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            link.reset_pin <= 1'b0;
            settle_reg     <= card_pkg::STEP_CYCLES;
            card_ready     <= 1'b0;
            irq            <= 1'b0;
        end
        else
        begin
            // RULE20: active low in disk mode
            link.reset_pin <= ata_select ? ~card_reset_req : card_reset_req;
            // ready is stale until the card sees reset
            if (card_reset_req)
                settle_reg <= card_pkg::STEP_CYCLES;
            else if (settle_reg != 8'h00)
                settle_reg <= settle_reg - 8'h01;
            card_ready <= ready_s;
            irq        <= ata_select ? ready_s : (io_configured & ~ready_s);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strobe cycle sequencer

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_reg              <= card_pkg::ST_IDLE;
            op_reg                 <= card_pkg::OP_MEM_READ;
            step_reg               <= 8'h00;
            cmd_ready              <= 1'b0;
            link.output_enable_n   <= 1'b1;
            link.io_read_strobe_n  <= 1'b1;
            link.io_write_strobe_n <= 1'b1;
            link.host_data         <= 16'h0000;
            link.host_data_oe      <= 1'b0;
        end
        else
        begin
            cmd_ready <= 1'b0;
            if (!step_done)
                step_reg <= step_reg - 8'h01;
            // RULE11: select held low
            if (ata_select)
                link.output_enable_n <= 1'b0;
            unique case (state_reg)
                card_pkg::ST_IDLE:
                begin
                    link.host_data_oe <= 1'b0;
                    // RULE7: write strobe stays negated
                    link.io_write_strobe_n <= 1'b1;
                    if (!ata_select)
                        link.output_enable_n <= 1'b1;
                    // RULE3: host ready or pause
                    if (dma_read_en)
                        link.io_read_strobe_n <= 1'b0;
                    else if (!dma_write_en)
                        link.io_read_strobe_n <= 1'b1;
                    cmd_ready <= ready_ok & ~(cmd_valid & cmd_ready);
                    if (cmd_valid && cmd_ready)
                    begin
                        op_reg         <= cmd_op;
                        link.host_data <= cmd_data;
                        step_reg       <= card_pkg::STEP_CYCLES;
                        state_reg      <= card_pkg::ST_SETUP;
                    end
                end
                card_pkg::ST_SETUP:
                begin
                    link.host_data_oe <= op_reg == card_pkg::OP_IO_WRITE
                                         || op_reg == card_pkg::OP_DMA_WRITE;
                    if (step_done)
                    begin
                        step_reg  <= card_pkg::STEP_CYCLES;
                        state_reg <= card_pkg::ST_STROBE;
                        unique case (op_reg)
                            card_pkg::OP_MEM_READ:
                                link.output_enable_n <= 1'b0;
                            card_pkg::OP_IO_READ:
                                link.io_read_strobe_n <= 1'b0;
                            // RULE5: one edge per word
                            card_pkg::OP_DMA_WRITE:
                                link.io_read_strobe_n <= ~link.io_read_strobe_n;
                            // RULE8: stop request
                            default:
                                link.io_write_strobe_n <= 1'b0;
                        endcase
                    end
                end
                card_pkg::ST_STROBE:
                begin
                    if (step_done)
                    begin
                        step_reg  <= card_pkg::STEP_CYCLES;
                        state_reg <= card_pkg::ST_HOLD;
                        link.io_write_strobe_n <= 1'b1;
                        if (op_reg == card_pkg::OP_IO_READ)
                            link.io_read_strobe_n <= 1'b1;
                        if (!ata_select)
                            link.output_enable_n <= 1'b1;
                    end
                end
                card_pkg::ST_HOLD:
                begin
                    if (step_done)
                        state_reg <= card_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read responses: strobe cycles and dma-in words

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            dstr_d_reg <= 1'b0;
            rsp_valid  <= 1'b0;
            rsp_data   <= 16'h0000;
        end
        else
        begin
            dstr_d_reg <= dstr_s;
            rsp_valid  <= 1'b0;
            if ((state_reg == card_pkg::ST_STROBE && step_done
                && (op_reg == card_pkg::OP_MEM_READ || op_reg == card_pkg::OP_IO_READ))
                || (dma_read_en && dstr_s != dstr_d_reg))
            begin
                rsp_valid <= 1'b1;
                rsp_data  <= bus_s;
            end
        end
    end
endmodule

// ===== verif/card_link_assertions.sv
// concurrent checks on the socket pins between host and card ends
// assumes the bench places it beside the link interface
module card_link_assertions (
    input wire logic        srst,              // card reset
    input wire logic        link_clk,          // link clock
    input wire logic        output_enable_n,   // output enable pin
    input wire logic        io_read_strobe_n,  // read strobe pin
    input wire logic        io_write_strobe_n, // write strobe pin
    input wire logic        ready_irq,         // ready or irq pin
    input wire logic        dev_strobe,        // card dma-in strobe
    input wire logic        dev_data_oe,       // card drives bus
    input wire logic        host_data_oe,      // host drives bus
    input wire logic [15:0] host_data          // host data out
);
    default clocking @(posedge link_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////
    a_read_gated:
    assert property ($rose(dev_data_oe)
        |-> !($past(io_read_strobe_n, 2) && $past(output_enable_n, 2)))
        else $error("drive without strobe");
    a_drive_release:
    assert property ((io_read_strobe_n && output_enable_n)[*6] |-> !dev_data_oe)
        else $error("drive after release");
    a_write_no_drive:
    assert property (!io_write_strobe_n |-> !dev_data_oe)
        else $error("drive during write");
    a_no_contend:
    assert property (dev_data_oe |-> !host_data_oe)
        else $error("bus contention");
    a_busy_after_reset:
    assert property ($fell(srst) |-> (!ready_irq)[*8])
        else $error("ready too early");
    a_quiet_while_busy:
    assert property ($fell(srst) |-> (io_read_strobe_n && io_write_strobe_n)[*8])
        else $error("strobe while busy");
    a_strobe_still:
    assert property (!dev_data_oe |=> $stable(dev_strobe))
        else $error("strobe moved idle");
    a_data_steady:
    assert property ($changed(io_read_strobe_n) && host_data_oe |-> $stable(host_data))
        else $error("data moved on edge");
    ////////////////////////////////////////////////////////////////
    c_read: cover property ($rose(dev_data_oe));
    c_ready: cover property ($rose(ready_irq));
    c_dma_edge: cover property ($changed(io_read_strobe_n) && host_data_oe);
endmodule

// ===== verif/card_host_strobe_ready_logic_tb.sv
// bench joining host and card ends over the link interface
// assumes the host end makes the link clock from clk
module card_host_strobe_ready_logic_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, srst = 1'b1, card_srst = 1'b1, ata = 1'b0, io_cfg = 1'b0, dma_w = 1'b0;
    logic cmd_valid = 1'b0, irq_req = 1'b0, busy = 1'b0, cmd_ready, rsp_valid, card_ready, irq;
    logic disk_mode, wr_valid, burst_stop;
    logic [15:0] cmd_data = 16'h0000, rd = 16'h0000, attr = 16'h0000, rsp_data, wr_data;
    card_pkg::op_t cmd_op = card_pkg::OP_MEM_READ;
    logic [31:0] seed = 32'h610785CE;
    logic [15:0] got_q[$];
    int fails = 0, n_tests = 0, n_stop = 0;
    card_link_if link ();
    card_host u_card_host (.clk(clk), .srst(srst), .link(link), .card_reset_req(1'b0),
        .ata_select(ata), .io_configured(io_cfg), .dma_read_en(1'b0), .dma_write_en(dma_w),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .card_ready(card_ready), .irq(irq));
    card_device u_card_device (.link(link), .srst(card_srst), .io_configured(io_cfg),
        .soft_reset(1'b0), .irq_pulse_mode(1'b0), .irq_request(irq_req), .user_busy(busy),
        .udma_write_en(dma_w), .udma_read_en(1'b0), .rd_data(rd), .attr_data(attr),
        .disk_interface_mode(disk_mode), .reset_active(), .wr_valid(wr_valid),
        .wr_data(wr_data), .burst_stop(burst_stop), .rd_take());
    card_link_assertions u_chk (.srst(card_srst), .link_clk(link.link_clk),
        .output_enable_n(link.output_enable_n), .io_read_strobe_n(link.io_read_strobe_n),
        .io_write_strobe_n(link.io_write_strobe_n), .ready_irq(link.ready_irq),
        .dev_strobe(link.dev_strobe), .dev_data_oe(link.dev_data_oe),
        .host_data_oe(link.host_data_oe), .host_data(link.host_data));
    ////////////////////////////////////////////////////////////////
    always #50 clk = ~clk;
    always @(posedge clk) if (rsp_valid === 1'b1) got_q.push_back(rsp_data);
    always @(posedge link.link_clk)
    begin
        if (wr_valid === 1'b1) got_q.push_back(wr_data);
        if (burst_stop === 1'b1) n_stop++;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // empty queue gives unknown: a lost word never matches
    function automatic logic [15:0] take();
        if (got_q.size() == 0) return 16'hXXXX;
        return got_q.pop_front();
    endfunction
    task automatic chk(input logic [15:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // spacing covers a strobe cycle and sync delay
    task automatic do_cmd(input card_pkg::op_t o, input logic [15:0] d);
        int k = 0;
        while (cmd_ready !== 1'b1 && k < 3000)
        begin
            @(negedge clk);
            k++;
        end
        if (k == 3000) fails++;
        cmd_op = o;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        repeat (260) @(negedge clk);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(negedge clk);
        srst = 1'b0;
        repeat (80) @(negedge clk);
        card_srst = 1'b0;
        repeat (20) @(negedge clk);
        chk(card_ready, 1'b0);
        repeat (1200) @(negedge clk);
        chk(card_ready, 1'b1);
        busy = 1'b1;
        repeat (100) @(negedge clk);
        chk(card_ready, 1'b0);
        busy = 1'b0;
        seed = lfsr(seed);
        rd = seed[15:0];
        attr = seed[31:16];
        do_cmd(card_pkg::OP_MEM_READ, 16'h0000);
        chk(take(), rd);
        $display("memory mode test done");
        io_cfg = 1'b1;
        do_cmd(card_pkg::OP_MEM_READ, 16'h0000);
        chk(take(), attr);
        do_cmd(card_pkg::OP_IO_READ, 16'h0000);
        chk(take(), rd);
        for (int i = 0; i < 3; i++)
        begin
            seed = lfsr(seed);
            do_cmd(card_pkg::OP_IO_WRITE, seed[15:0]);
            chk(take(), seed[15:0]);
        end
        irq_req = 1'b1;
        repeat (100) @(negedge clk);
        chk(link.ready_irq, 1'b0);
        chk(irq, 1'b1);
        irq_req = 1'b0;
        $display("io mode test done");
        // strap taken at reset release
        io_cfg = 1'b0;
        ata = 1'b1;
        card_srst = 1'b1;
        repeat (80) @(negedge clk);
        card_srst = 1'b0;
        repeat (1300) @(negedge clk);
        chk(disk_mode, 1'b1);
        irq_req = 1'b1;
        repeat (100) @(negedge clk);
        chk(link.ready_irq, 1'b1);
        irq_req = 1'b0;
        do_cmd(card_pkg::OP_IO_READ, 16'h0000);
        chk(take(), rd);
        $display("disk mode test done");
        dma_w = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            do_cmd(card_pkg::OP_DMA_WRITE, seed[15:0]);
            chk(take(), seed[15:0]);
            repeat (seed[20:16]) @(negedge clk);
        end
        do_cmd(card_pkg::OP_DMA_STOP, 16'h0000);
        chk(16'(n_stop), 16'h0001);
        do_cmd(card_pkg::OP_DMA_WRITE, seed[31:16]);
        chk(16'(got_q.size()), 16'h0000);
        dma_w = 1'b0;
        $display("dma test done");
        final_report();
    end
endmodule
